// ### hdl/servo_param_pkg.sv
// Package for the servo parameter decode block: codes, field layouts, timing.
// Assumes a single 100 MHz core clock; all parameter values arrive as plain ports.
package servo_param_pkg;
   localparam int CLK_MHZ = 100;
   // Operation mode codes
   localparam logic [3:0] MODE_TORQUE = 4'h0;
   localparam logic [3:0] MODE_SPEED = 4'h1;
   localparam logic [3:0] MODE_POSITION = 4'h2;
   localparam logic [3:0] MODE_POS_SPEED = 4'h3;
   localparam logic [3:0] MODE_SPEED_TORQUE = 4'h4;
   localparam logic [3:0] MODE_POS_TORQUE = 4'h5;
   // Active control loop, one-hot
   typedef enum logic [2:0] {
      LOOP_TORQUE = 3'h1,
      LOOP_SPEED = 3'h2,
      LOOP_POSITION = 3'h4
   } loop_t;
   // Encoder kind codes
   localparam logic [3:0] ENC_INC_PARALLEL = 4'h0;
   localparam logic [3:0] ENC_SERIAL_SINGLE = 4'h1;
   localparam logic [3:0] ENC_SERIAL_MULTI = 4'h3;
   localparam logic [4:0] ENC_SERIAL_BITS = 5'h13;
   // Baud codes and rates
   localparam logic [1:0] BAUD_9600 = 2'h0;
   localparam logic [1:0] BAUD_19200 = 2'h1;
   localparam logic [1:0] BAUD_38400 = 2'h2;
   localparam logic [1:0] BAUD_57600 = 2'h3;
   localparam int BAUD_RATE_0 = 9600;
   localparam int BAUD_RATE_1 = 19200;
   localparam int BAUD_RATE_2 = 38400;
   localparam int BAUD_RATE_3 = 57600;
   // Digit fields: each digit is one hex nibble
   localparam int DIGIT_W = 4;
   localparam int DIGIT1_LSB = 0;
   localparam int DIGIT2_LSB = 4;
   localparam int DIGIT3_LSB = 8;
   localparam int DIGIT4_LSB = 12;
   localparam int DIGIT5_LSB = 16;
   // Start-up display item range
   localparam logic [4:0] STATUS_ITEM_FIRST = 5'h00;
   localparam logic [4:0] STATUS_ITEM_LAST = 5'h19;
   // Stop mode codes
   localparam logic [1:0] STOP_DB_HOLD = 2'h0;
   localparam logic [1:0] STOP_DB_RELEASE = 2'h1;
   localparam logic [1:0] STOP_FREE_RELEASE = 2'h2;
   localparam logic [1:0] STOP_FREE_HOLD = 2'h3;
   // PWM off delay
   localparam int PWM_DELAY_MAX_MS = 1000;
   localparam int PWM_DELAY_INIT_MS = 10;
   localparam int MS_NS = 1000000;
   localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
   // Monitor refresh
   localparam int MON_PERIOD_US = 200;
   localparam int MON_PERIOD_CYCLES = MON_PERIOD_US * CLK_MHZ;
   // Monitor source codes
   localparam logic [3:0] MON_SPEED_FB = 4'h0;
   localparam logic [3:0] MON_SPEED_CMD = 4'h1;
   localparam logic [3:0] MON_TORQUE_FB = 4'h2;
   localparam logic [3:0] MON_TORQUE_CMD = 4'h3;
   localparam logic [3:0] MON_POS_FREQ = 4'h4;
   localparam logic [3:0] MON_FOLLOW_ERR = 4'h5;
   localparam logic [3:0] MON_DC_LINK = 4'h6;
   localparam logic [3:0] MON_USER_SPEED = 4'hd;
   localparam logic [3:0] MON_USER_TORQUE = 4'he;
   localparam int PCT_FULL = 100;
   localparam int DATA_W = 16;

   // Extracts one hex digit (1-based position given as its LSB)
   function automatic logic [3:0] digit_of(input logic [19:0] word, input int lsb);
      digit_of = word[lsb +: DIGIT_W];
   endfunction
endpackage

// ### hdl/pwm_off_timer.sv
// PWM off delay timer: holds PWM on for a programmed time after servo off.
// Assumes servo_on_in is already synchronised to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module pwm_off_timer
   import servo_param_pkg::*;
#(
   parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic servo_on_in,
   input wire logic [9:0] pwm_off_delay_in,
   output logic pwm_enable_out
);
   logic [16:0] cyc_reg, cyc_next;
   logic [9:0] ms_reg, ms_next;
   logic pwm_reg, pwm_next;

   // Count whole milliseconds after servo off, then drop PWM
   always_comb begin
      cyc_next = cyc_reg;
      ms_next = ms_reg;
      pwm_next = pwm_reg;
      if (servo_on_in) begin
         pwm_next = 1'b1;
         cyc_next = '0;
         ms_next = '0;
      end else if (pwm_reg) begin
         if (ms_reg >= pwm_off_delay_in) begin // RQ13
            pwm_next = 1'b0;
         end else if (cyc_reg == 17'(CYCLES_PER_MS_P - 1)) begin
            cyc_next = '0;
            ms_next = ms_reg + 10'h001;
         end else begin
            cyc_next = cyc_reg + 17'h00001;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         cyc_reg <= '0;
         ms_reg <= '0;
         pwm_reg <= 1'b0;
      end else begin
         cyc_reg <= cyc_next;
         ms_reg <= ms_next;
         pwm_reg <= pwm_next;
      end
   end

   assign pwm_enable_out = pwm_reg;

   pwm_drop_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      $fell(pwm_reg) |-> !$past(servo_on_in) && ms_reg >= pwm_off_delay_in) // RQ13
      else $error("PWM dropped before delay expired");
   pwm_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      servo_on_in |=> pwm_reg) // RQ13
      else $error("PWM not enabled while servo on");
endmodule // pwm_off_timer
`default_nettype wire

// ### hdl/encoder_rescale.sv
// Encoder repeat output: rescales quadrature counts so one revolution gives the
// programmed count. Assumes enc_step_in is a same-clock one-cycle pulse per count.
`timescale 1ns/1ps
`default_nettype none
module encoder_rescale #(
   parameter int CNT_W = 20
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic enc_step_in,
   input wire logic [CNT_W-1:0] counts_per_rev_in,
   input wire logic [CNT_W-1:0] out_per_rev_in,
   output logic out_step_out
);
   logic [CNT_W:0] acc_reg, acc_next;
   logic step_reg, step_next;

   // Bresenham accumulator; limitation: output rate cannot exceed input rate
   always_comb begin
      logic [CNT_W:0] sum;
      sum = '0;
      acc_next = acc_reg;
      step_next = 1'b0;
      if (enc_step_in) begin
         sum = acc_reg + {1'b0, out_per_rev_in};
         if (sum >= {1'b0, counts_per_rev_in}) begin // RQ12
            acc_next = sum - {1'b0, counts_per_rev_in};
            step_next = 1'b1;
         end else begin
            acc_next = sum;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         acc_reg <= '0;
         step_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         step_reg <= step_next;
      end
   end

   assign out_step_out = step_reg;

   step_cause_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      step_reg |-> $past(enc_step_in)) // RQ12
      else $error("Repeat pulse without encoder step");
endmodule // encoder_rescale
`default_nettype wire

// ### hdl/servo_param_decode.sv
// Servo system parameter decode: mode, encoder, baud, power, stop, function digits,
// alarm outputs and monitor refresh. Assumes parameters are static from software
// and contact/pin inputs are asynchronous to core_clk_in.
// What this block does
// [RQ1] Codes 0,1,2 give torque, speed, position
// [RQ2] Code 3: contact on position, off speed
// [RQ3] Code 4: contact on speed, off torque
// [RQ4] Code 5: contact on position, off torque
// [RQ5] Encoder kinds: incremental, single, multi serial
// [RQ6] Baud codes map to 9600..57600
// [RQ7] Power digit1 selects single or three phase
// [RQ8] Power digit2: phase loss error or warning
// [RQ9] Show chosen status item at power-up
// [RQ10] Zero regen setting uses built-in rating
// [RQ11] Warn at programmed percent of overload
// [RQ12] Repeat output rescaled to programmed count
// [RQ13] Hold PWM for delay after servo off
// [RQ14] Stop modes: brake or free, hold/release
// [RQ15] Digit1 selects forward rotation direction
// [RQ16] Digit2 locks motor at zero speed command in speed loop
// [RQ17] Digit3 turns alarm pins to encoder ABZ
// [RQ18] Alarm pins carry binary alarm group
// [RQ19] Digit4 selects bipolar or unipolar monitors
// [RQ20] Digit5 selects saving comm writes
// [RQ21] Refresh both monitors every 200 us
// [RQ22] Monitor source codes select data
`timescale 1ns/1ps
`default_nettype none
module servo_param_decode
   import servo_param_pkg::*;
#(
   parameter int MON_CYCLES_P = MON_PERIOD_CYCLES,
   parameter int CYCLES_PER_MS_P = CYCLES_PER_MS,
   parameter logic [15:0] DEFAULT_REGEN_OHMS = 16'h0028,
   parameter logic [15:0] DEFAULT_REGEN_WATTS = 16'h0064
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic [3:0] control_mode_select_in,
   input wire logic mode_contact_in,
   input wire logic [3:0] encoder_kind_select_in,
   input wire logic [19:0] encoder_ppr_in,
   input wire logic [1:0] baud_code_in,
   input wire logic [7:0] mains_input_config_in,
   input wire logic phase_loss_in,
   input wire logic [4:0] startup_display_select_in,
   input wire logic [15:0] regen_resistor_value_in,
   input wire logic [15:0] regen_resistor_capacity_in,
   input wire logic [7:0] overload_warn_level_in,
   input wire logic [7:0] overload_load_pct_in,
   input wire logic enc_step_in,
   input wire logic [19:0] encoder_repeat_scale_in,
   input wire logic enc_a_in,
   input wire logic enc_b_in,
   input wire logic enc_z_in,
   input wire logic servo_on_in,
   input wire logic [9:0] pwm_off_delay_in,
   input wire logic [1:0] stop_mode_select_in,
   input wire logic [19:0] function_digits_in,
   input wire logic speed_cmd_zero_in,
   input wire logic [2:0] alarm_group_in,
   input wire logic [7:0] monitor_source_select_in,
   input wire logic [DATA_W-1:0] mon_data_in [0:8],
   output logic [2:0] loop_select_out,
   output logic serial_encoder_out,
   output logic multi_turn_out,
   output logic [4:0] encoder_bits_out,
   output logic [15:0] baud_rate_out,
   output logic three_phase_out,
   output logic phase_loss_error_out,
   output logic phase_loss_warning_out,
   output logic [4:0] display_item_out,
   output logic [15:0] regen_ohms_out,
   output logic [15:0] regen_watts_out,
   output logic overload_warning_out,
   output logic encoder_repeat_out,
   output logic pwm_enable_out,
   output logic dynamic_brake_out,
   output logic brake_hold_out,
   output logic cw_forward_out,
   output logic zero_lock_out,
   output logic alarm_code_bit0_out,
   output logic alarm_code_bit1_out,
   output logic alarm_code_bit2_out,
   output logic monitor_unipolar_out,
   output logic comm_save_enable_out,
   output logic [DATA_W-1:0] monitor1_out,
   output logic [DATA_W-1:0] monitor2_out,
   output logic monitor_update_out
);
   // Two-flop synchronisers for pin inputs
   logic [6:0] pin_meta_reg, pin_sync_reg;
   logic contact_s, phase_loss_s, servo_on_s, zero_s, enc_a_s, enc_b_s, enc_z_s;
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= {mode_contact_in, phase_loss_in, servo_on_in, speed_cmd_zero_in,
                          enc_a_in, enc_b_in, enc_z_in};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   assign {contact_s, phase_loss_s, servo_on_s, zero_s, enc_a_s, enc_b_s, enc_z_s} =
      pin_sync_reg;

   // Loop choice from mode code and contact
   function automatic loop_t mode_loop(input logic [3:0] code, input logic contact);
      case (code)
         MODE_TORQUE: mode_loop = LOOP_TORQUE; // RQ1
         MODE_SPEED: mode_loop = LOOP_SPEED; // RQ1
         MODE_POSITION: mode_loop = LOOP_POSITION; // RQ1
         MODE_POS_SPEED: mode_loop = contact ? LOOP_POSITION : LOOP_SPEED; // RQ2
         MODE_SPEED_TORQUE: mode_loop = contact ? LOOP_SPEED : LOOP_TORQUE; // RQ3
         MODE_POS_TORQUE: mode_loop = contact ? LOOP_POSITION : LOOP_TORQUE; // RQ4
         default: mode_loop = LOOP_TORQUE; // Undefined codes fall back to torque
      endcase
   endfunction

   loop_t loop_reg, loop_next;
   logic [7:0] dec_reg, dec_next;
   logic [4:0] disp_reg, disp_next;
   logic [15:0] baud_reg, baud_next, ohms_reg, ohms_next, watts_reg, watts_next;
   logic [4:0] ebits_reg, ebits_next;
   logic [2:0] alarm_reg, alarm_next;
   logic ovl_reg, ovl_next, started_reg, started_next;
   logic [3:0] d1, d2, d3, d4, d5;
   logic [15:0] warn_prod, load_prod;
   logic speed_mode;

   assign d1 = digit_of(function_digits_in, DIGIT1_LSB);
   assign d2 = digit_of(function_digits_in, DIGIT2_LSB);
   assign d3 = digit_of(function_digits_in, DIGIT3_LSB);
   assign d4 = digit_of(function_digits_in, DIGIT4_LSB);
   assign d5 = digit_of(function_digits_in, DIGIT5_LSB);
   // Warning threshold: load*100 >= level*trip level (trip level = 100 %)
   assign load_prod = 16'(overload_load_pct_in) * 16'(PCT_FULL);
   assign warn_prod = 16'(overload_warn_level_in) * 16'(PCT_FULL);
   assign speed_mode = (loop_reg == LOOP_SPEED);

   // Decode next values; bits of dec: three_phase, pl_err, pl_warn, db, hold, cw, zlock, uni
   always_comb begin
      loop_next = mode_loop(control_mode_select_in, contact_s);
      dec_next[7] = digit_of({12'h000, mains_input_config_in}, DIGIT1_LSB) == 4'h1; // RQ7
      dec_next[6] = phase_loss_s
         && digit_of({12'h000, mains_input_config_in}, DIGIT2_LSB) == 4'h0; // RQ8
      dec_next[5] = phase_loss_s
         && digit_of({12'h000, mains_input_config_in}, DIGIT2_LSB) == 4'h1; // RQ8
      dec_next[4] = !pwm_enable_out && (stop_mode_select_in == STOP_DB_HOLD
         || stop_mode_select_in == STOP_DB_RELEASE); // RQ14
      dec_next[3] = !pwm_enable_out && (stop_mode_select_in == STOP_DB_HOLD
         || stop_mode_select_in == STOP_FREE_HOLD); // RQ14
      dec_next[2] = d1 == 4'h1; // RQ15
      dec_next[1] = d2 == 4'h1 && speed_mode && zero_s; // RQ16
      dec_next[0] = d4 == 4'h1; // RQ19
      case (baud_code_in) // RQ6
         BAUD_9600: baud_next = 16'(BAUD_RATE_0);
         BAUD_19200: baud_next = 16'(BAUD_RATE_1);
         BAUD_38400: baud_next = 16'(BAUD_RATE_2);
         default: baud_next = 16'(BAUD_RATE_3);
      endcase
      case (encoder_kind_select_in) // RQ5
         ENC_SERIAL_SINGLE, ENC_SERIAL_MULTI: ebits_next = ENC_SERIAL_BITS;
         default: ebits_next = '0; // Incremental uses pulses per revolution instead
      endcase
      ohms_next = (regen_resistor_value_in == 16'h0000) ? DEFAULT_REGEN_OHMS
         : regen_resistor_value_in; // RQ10
      watts_next = (regen_resistor_capacity_in == 16'h0000) ? DEFAULT_REGEN_WATTS
         : regen_resistor_capacity_in; // RQ10
      ovl_next = load_prod >= warn_prod; // RQ11
      // Capture start-up item once after reset; out-of-range codes show the first item
      started_next = 1'b1;
      disp_next = disp_reg;
      if (!started_reg) begin
         disp_next = (startup_display_select_in <= STATUS_ITEM_LAST)
            ? startup_display_select_in : STATUS_ITEM_FIRST; // RQ9
      end
      // Alarm pins: group code, or encoder A/B/Z when repurposed
      alarm_next = (d3 == 4'h1) ? {enc_z_s, enc_b_s, enc_a_s} : alarm_group_in; // RQ17 RQ18
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         loop_reg <= LOOP_TORQUE;
         dec_reg <= '0;
         disp_reg <= STATUS_ITEM_FIRST;
         baud_reg <= '0;
         ebits_reg <= '0;
         ohms_reg <= '0;
         watts_reg <= '0;
         ovl_reg <= 1'b0;
         started_reg <= 1'b0;
         alarm_reg <= '0;
      end else begin
         loop_reg <= loop_next;
         dec_reg <= dec_next;
         disp_reg <= disp_next;
         baud_reg <= baud_next;
         ebits_reg <= ebits_next;
         ohms_reg <= ohms_next;
         watts_reg <= watts_next;
         ovl_reg <= ovl_next;
         started_reg <= started_next;
         alarm_reg <= alarm_next;
      end
   end

   // Monitor refresh: both channels latched together each period
   logic [31:0] mon_cnt_reg, mon_cnt_next;
   logic [DATA_W-1:0] mon1_reg, mon1_next, mon2_reg, mon2_next;
   logic mon_upd_reg, mon_upd_next;

   function automatic logic [DATA_W-1:0] mon_pick(input logic [3:0] code,
                                                  input logic [DATA_W-1:0] src [0:8]);
      case (code) // RQ22
         MON_SPEED_FB: mon_pick = src[0];
         MON_SPEED_CMD: mon_pick = src[1];
         MON_TORQUE_FB: mon_pick = src[2];
         MON_TORQUE_CMD: mon_pick = src[3];
         MON_POS_FREQ: mon_pick = src[4];
         MON_FOLLOW_ERR: mon_pick = src[5];
         MON_DC_LINK: mon_pick = src[6];
         MON_USER_SPEED: mon_pick = src[7];
         MON_USER_TORQUE: mon_pick = src[8];
         default: mon_pick = '0; // Unlisted codes output zero
      endcase
   endfunction

   always_comb begin
      mon_cnt_next = mon_cnt_reg + 32'h0000_0001;
      mon1_next = mon1_reg;
      mon2_next = mon2_reg;
      mon_upd_next = 1'b0;
      if (mon_cnt_reg == 32'(MON_CYCLES_P - 1)) begin // RQ21
         mon_cnt_next = '0;
         mon_upd_next = 1'b1;
         mon1_next = mon_pick(monitor_source_select_in[3:0], mon_data_in);
         mon2_next = mon_pick(monitor_source_select_in[7:4], mon_data_in);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         mon_cnt_reg <= '0;
         mon1_reg <= '0;
         mon2_reg <= '0;
         mon_upd_reg <= 1'b0;
      end else begin
         mon_cnt_reg <= mon_cnt_next;
         mon1_reg <= mon1_next;
         mon2_reg <= mon2_next;
         mon_upd_reg <= mon_upd_next;
      end
   end

   pwm_off_timer #(
      .CYCLES_PER_MS_P(CYCLES_PER_MS_P)
   ) u_pwm (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .servo_on_in(servo_on_s),
      .pwm_off_delay_in(pwm_off_delay_in),
      .pwm_enable_out(pwm_enable_out)
   );

   encoder_rescale #(
      .CNT_W(20)
   ) u_rescale (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .enc_step_in(enc_step_in),
      .counts_per_rev_in(encoder_ppr_in),
      .out_per_rev_in(encoder_repeat_scale_in),
      .out_step_out(encoder_repeat_out)
   );

   assign loop_select_out = loop_reg;
   assign serial_encoder_out = ebits_reg != 5'h00;
   assign multi_turn_out = encoder_kind_select_in == ENC_SERIAL_MULTI; // RQ5
   assign encoder_bits_out = ebits_reg;
   assign baud_rate_out = baud_reg;
   assign {three_phase_out, phase_loss_error_out, phase_loss_warning_out, dynamic_brake_out,
           brake_hold_out, cw_forward_out, zero_lock_out, monitor_unipolar_out} = dec_reg;
   assign display_item_out = disp_reg;
   assign regen_ohms_out = ohms_reg;
   assign regen_watts_out = watts_reg;
   assign overload_warning_out = ovl_reg;
   assign {alarm_code_bit2_out, alarm_code_bit1_out, alarm_code_bit0_out} = alarm_reg;
   assign comm_save_enable_out = d5 == 4'h0; // RQ20
   assign monitor1_out = mon1_reg;
   assign monitor2_out = mon2_reg;
   assign monitor_update_out = mon_upd_reg;

   // Assertions
   sequence s_tick;
      mon_upd_reg;
   endsequence
   fixed_modes_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      $stable(control_mode_select_in) && control_mode_select_in == MODE_POSITION
      |=> loop_reg == LOOP_POSITION) // RQ1
      else $error("Mode 2 not position");
   pos_speed_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      control_mode_select_in == MODE_POS_SPEED |=> loop_reg == (($past(contact_s))
      ? LOOP_POSITION : LOOP_SPEED)) // RQ2
      else $error("Mode 3 wrong loop");
   speed_torque_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      control_mode_select_in == MODE_SPEED_TORQUE && !contact_s |=> loop_reg == LOOP_TORQUE) // RQ3
      else $error("Mode 4 wrong loop");
   pos_torque_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      control_mode_select_in == MODE_POS_TORQUE && contact_s |=> loop_reg == LOOP_POSITION) // RQ4
      else $error("Mode 5 wrong loop");
   baud_map_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      baud_code_in == BAUD_38400 |=> baud_reg == 16'(BAUD_RATE_2)) // RQ6
      else $error("Baud 38400 not mapped");
   phase_loss_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      phase_loss_s |=> phase_loss_error_out || phase_loss_warning_out) // RQ8
      else $error("Phase loss neither error nor warning");
   regen_default_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      regen_resistor_value_in == 16'h0000 |=> regen_ohms_out == DEFAULT_REGEN_OHMS) // RQ10
      else $error("Regen default not used");
   alarm_group_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      d3 != 4'h1 |=> alarm_reg == $past(alarm_group_in)) // RQ18
      else $error("Alarm pins not group code");
   mon_period_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      s_tick |=> !mon_upd_reg [*2]) // RQ21
      else $error("Monitor refreshed too soon");
   display_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      started_reg |=> $stable(disp_reg)) // RQ9
      else $error("Start-up display changed after capture");
endmodule // servo_param_decode
`default_nettype wire

// ### testbench/host_contact_model.sv
// Host-side model: drives the contacts and encoder pins a controller would.
// Assumes it shares core_clk_in with the bench; pins move only after an edge.
`timescale 1ns/1ps
`default_nettype none
module host_contact_model (
   input wire logic core_clk_in,
   input wire logic [4:0] pin_req_in,
   output logic [4:0] pins_out
);
   // Pins here change only just after a clock edge, so register the request first
   always_ff @(posedge core_clk_in) begin
      pins_out <= pin_req_in;
   end
endmodule // host_contact_model
`default_nettype wire

// ### testbench/servo_param_decode_tb_top.sv
// Bench for the parameter decode: drivers note expectations, a watcher compares.
// Assumes short monitor and millisecond counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module servo_param_decode_tb_top;
   import servo_param_pkg::*;
   typedef struct {int s; logic [15:0] e;} note_t;
   logic clk = 0, rst_n = 0, ph = 0, zc = 0, ser, mt, three, perr, pwarn, olw, rep, pwm, db, hold;
   logic cw, zl, a0, a1, a2, uni, csv, upd;
   logic [3:0] mode = 0, ek = 0;
   logic [1:0] baud = 0, stop = 0;
   logic [7:0] mains = 0, lvl = 0, pct = 0, msel = 0;
   logic [4:0] disp = 5'h07, preq = 0, pins, bits, item;
   logic [15:0] rval = 0, rate, ohms, watts, m1, m2, r;
   logic [19:0] fd = 0;
   logic [2:0] grp = 0, lsel;
   logic [15:0] md [0:8];
   logic [15:0] obs [0:14];
   logic [15:0] rt [0:3] = '{16'h2580, 16'h4b00, 16'h9600, 16'he100};
   logic [3:0] mc [0:9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hd, 4'he, 4'h7};
   note_t q [$];
   int mismatches = 0, cmp_count = 0, nrep, nupd, nbase;
   event take;
   host_contact_model host_contact_model_i (.core_clk_in(clk), .pin_req_in(preq), .pins_out(pins));
   servo_param_decode #(.MON_CYCLES_P(8), .CYCLES_PER_MS_P(4))
   servo_param_decode_i (.core_clk_in(clk), .reset_n_in(rst_n), .control_mode_select_in(mode),
      .mode_contact_in(pins[3]), .encoder_kind_select_in(ek), .encoder_ppr_in(20'h00400),
      .baud_code_in(baud), .mains_input_config_in(mains), .phase_loss_in(ph),
      .startup_display_select_in(disp), .regen_resistor_value_in(rval),
      .regen_resistor_capacity_in(rval), .overload_warn_level_in(lvl), .overload_load_pct_in(pct),
      .enc_step_in(zc), .encoder_repeat_scale_in(20'h00100), .enc_a_in(pins[2]),
      .enc_b_in(pins[1]), .enc_z_in(pins[0]), .servo_on_in(pins[4]), .pwm_off_delay_in(10'h002),
      .stop_mode_select_in(stop), .function_digits_in(fd), .speed_cmd_zero_in(zc),
      .alarm_group_in(grp), .monitor_source_select_in(msel), .mon_data_in(md),
      .loop_select_out(lsel), .serial_encoder_out(ser), .multi_turn_out(mt), .encoder_bits_out(bits),
      .baud_rate_out(rate), .three_phase_out(three), .phase_loss_error_out(perr),
      .phase_loss_warning_out(pwarn), .display_item_out(item), .regen_ohms_out(ohms),
      .regen_watts_out(watts), .overload_warning_out(olw), .encoder_repeat_out(rep),
      .pwm_enable_out(pwm), .dynamic_brake_out(db), .brake_hold_out(hold), .cw_forward_out(cw),
      .zero_lock_out(zl), .alarm_code_bit0_out(a0), .alarm_code_bit1_out(a1),
      .alarm_code_bit2_out(a2), .monitor_unipolar_out(uni), .comm_save_enable_out(csv),
      .monitor1_out(m1), .monitor2_out(m2), .monitor_update_out(upd));
   // Output groups, zero extended
   always_comb begin
      obs[0] = {13'h0, lsel};
      obs[1] = rate;
      obs[2] = {13'h0, three, perr, pwarn};
      obs[3] = {9'h0, ser, mt, bits};
      obs[4] = {13'h0, pwm, db, hold};
      obs[5] = {13'h0, a2, a1, a0};
      obs[6] = {12'h0, zl, cw, uni, csv};
      obs[7] = ohms;
      obs[8] = {15'h0, olw};
      obs[9] = m1;
      obs[10] = m2;
      obs[11] = {11'h0, item};
      obs[12] = 16'(nrep);
      obs[13] = 16'(nupd - nbase);
      obs[14] = watts;
   end
   // Pulse counters
   always @(posedge clk) begin
      nrep += rep;
      nupd += upd;
   end
   // Free-running clock
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Pause so the watcher takes one note at a time
   task automatic note(input int s, input logic [15:0] e);
      q.push_back('{s, e});
      ->take;
      #2;
   endtask
   task automatic cmp_lvl(input int s, input logic [15:0] e);
      cmp_count++;
      if (obs[s] !== e) begin
         mismatches++;
         $display("[FAIL] output group %0d expected %h seen %h", s, e, obs[s]);
      end
   endtask
   function automatic logic [2:0] loop_of(input int m, input int c);
      case (m)
         1: return 3'h2;
         2: return 3'h4;
         3: return c ? 3'h4 : 3'h2;
         4: return c ? 3'h2 : 3'h1;
         5: return c ? 3'h4 : 3'h1;
         default: return 3'h1;
      endcase
   endfunction
   // Unlisted source codes read back as zero
   function automatic logic [15:0] mon_of(input logic [3:0] c);
      return c < 4'h7 ? md[c] : c == 4'hd ? md[7] : c == 4'he ? md[8] : 16'h0000;
   endfunction
   // Watcher: compares settled outputs with the oldest note
   initial begin
      forever begin
         @(take);
         #1;
         cmp_lvl(q[0].s, q[0].e);
         void'(q.pop_front());
      end
   end
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog well above the test length
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h0ab6));
      for (int i = 0; i < 9; i++) md[i] = $urandom;
      wt(12);
      rst_n <= 1'b1;
      wt(6);
      note(11, 16'h0007);
      for (int m = 0; m < 6; m++) for (int c = 0; c < 2; c++) begin
         mode <= m[3:0];
         preq[3] <= c[0];
         wt(6);
         note(0, {13'h0, loop_of(m, c)});
      end
      for (int b = 0; b < 4; b++) begin
         baud <= b[1:0];
         ek <= b[1:0];
         wt(3);
         note(1, rt[b]);
         if (b != 2) note(3, {9'h0, b != 0, b == 3, b != 0 ? 5'h13 : 5'h00});
      end
      for (int v = 0; v < 4; v++) begin
         mains <= {3'h0, v[1], 3'h0, v[0]};
         ph <= 1'b1;
         wt(6);
         note(2, {13'h0, v[0], !v[1], v[1]});
      end
      $display("decode tests done");
      r = $urandom;
      for (int i = 0; i < 2; i++) begin
         rval <= i ? (r | 16'h0001) : 16'h0000;
         lvl <= r[7:0] | 8'h01;
         pct <= (r[7:0] | 8'h01) - 8'(1 - i);
         wt(3);
         note(7, i ? (r | 16'h0001) : 16'h0028);
         note(8, 16'(i));
         note(14, i ? (r | 16'h0001) : 16'h0064);
      end
      for (int i = 0; i < 8; i++) begin
         fd <= {3'h0, i[2], 3'h0, i[1], 8'h00, 3'h0, i[0]};
         grp <= i[2:0];
         wt(3);
         note(6, {13'h0, i[0], i[1], !i[2]});
         note(5, 16'(i));
      end
      fd <= 20'h00100;
      preq[2:0] <= 3'b110;
      wt(6);
      note(5, 16'h0003);
      mode <= 4'h1;
      fd <= 20'h00010;
      zc <= 1'b1;
      wt(8);
      note(6, 16'h0009);
      zc <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         stop <= s[1:0];
         preq[4] <= 1'b1;
         wt(6);
         preq[4] <= 1'b0;
         wt(8);
         note(4, 16'h0004);
         wt(12);
         note(4, {14'h0, s < 2, s == 0 || s == 3});
      end
      note(12, 16'h0002);
      $display("pin tests done");
      for (int k = 0; k < 10; k++) begin
         msel <= {mc[(k + 1) % 10], mc[k]};
         nbase = nupd;
         wt(16);
         note(9, mon_of(mc[k]));
         note(10, mon_of(mc[(k + 1) % 10]));
         note(13, 16'h0002);
      end
      $display("monitor tests done");
      wrap_up();
   end
endmodule // servo_param_decode_tb_top
`default_nettype wire
